// ### exec_cfg.svh
// Purpose: constants for the instruction execute slice
// Assumes: 14-bit instruction words, 8-bit data path
// Notes:   offsets, field positions, encodings and reset values
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define FILE_ADDR_W      7
`define PC_W             13
`define STACK_DEPTH      8
`define STACK_PTR_W      3
// file addresses for registers held inside this slice
`define ADDR_TIMER_CFG   7'h01
`define ADDR_IRQ_CTRL    7'h0B
`define ADDR_UPPER_LATCH 7'h0A
// field positions
`define IRQ_ENABLE_BIT   7
`define DEST_BIT         7
`define LATCH_HI_BIT     4
`define LATCH_LO_BIT     3
// fixed opcode words
`define OP_CFG_LOAD      14'h0062
`define OP_RET_IRQ       14'h0009
// reset values
`define TIMER_CFG_RESET  8'hFF
`define PC_RESET         13'h0000
`endif

// ### exec_pkg.sv
// Purpose: types for the instruction execute slice
// Assumes: nothing beyond the constants header
// Notes:   carriers between decoder, stack and main slice
package exec_pkg;
    typedef enum logic [3:0] {
        OP_IDLE     = 4'h0,
        OP_JUMP     = 4'h1,
        OP_INC      = 4'h2,
        OP_INC_SKIP = 4'h3,
        OP_OR_LIT   = 4'h4,
        OP_OR_FILE  = 4'h5,
        OP_LOAD_LIT = 4'h6,
        OP_MOVE     = 4'h7,
        OP_STORE    = 4'h8,
        OP_CFG_LOAD = 4'h9,
        OP_RET_IRQ  = 4'hA,
        OP_RET_LIT  = 4'hB,
        OP_OTHER    = 4'hC
    } op_type;

    typedef struct packed {
        op_type     op;     // decoded operation
        logic       dest;   // 1 = file register, 0 = accumulator
        logic [6:0] addr;   // file address field
        logic [7:0] lit;    // literal field
        logic [10:0] target; // jump target field
    } decode_type;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FLUSH = 1'b1
    } phase_type;
endpackage

// ### instr_decode.sv
// Purpose: combinational decode of one instruction word
// Assumes: word is stable during the execute cycle
// Notes:   unknown words decode as OP_OTHER and are ignored
`timescale 1ns/1ps
`include "exec_cfg.svh"
module instr_decode (
    input  wire logic [13:0]         word,    // fetched instruction
    output exec_pkg::decode_type     dec      // decoded fields
);
    // field extraction and opcode match
    always_comb begin
        dec.dest   = word[`DEST_BIT];
        dec.addr   = word[6:0];
        dec.lit    = word[7:0];
        dec.target = word[10:0];
        dec.op     = exec_pkg::OP_OTHER;
        if (word[13:11] == 3'b101) begin
            dec.op = exec_pkg::OP_JUMP;
        end else if (word[13:10] == 4'b1110 && word[9:8] == 2'b00) begin
            dec.op = exec_pkg::OP_OR_LIT;
        end else if (word[13:10] == 4'b1100) begin
            dec.op = exec_pkg::OP_LOAD_LIT;
        end else if (word[13:10] == 4'b1101) begin
            dec.op = exec_pkg::OP_RET_LIT;
        end else if (word[13:8] == 6'b001010) begin
            dec.op = exec_pkg::OP_INC;
        end else if (word[13:8] == 6'b001111) begin
            dec.op = exec_pkg::OP_INC_SKIP;
        end else if (word[13:8] == 6'b000100) begin
            dec.op = exec_pkg::OP_OR_FILE;
        end else if (word[13:8] == 6'b001000) begin
            dec.op = exec_pkg::OP_MOVE;
        end else if (word[13:7] == 7'b0000001) begin
            dec.op = exec_pkg::OP_STORE;
        end else if (word == `OP_CFG_LOAD) begin
            dec.op = exec_pkg::OP_CFG_LOAD;
        end else if (word == `OP_RET_IRQ) begin
            dec.op = exec_pkg::OP_RET_IRQ;
        end else if (word[13:7] == 7'b0000000 && word[4:0] == 5'b00000) begin
            dec.op = exec_pkg::OP_IDLE;
        end
    end
endmodule

// ### return_stack.sv
// Purpose: hardware return stack of program counter values
// Assumes: push and pop never in the same cycle
// Notes:   circular; overflow wraps and overwrites the oldest entry
`timescale 1ns/1ps
`include "exec_cfg.svh"
module return_stack (
    input  wire logic                 ref_clk,  // instruction clock
    input  wire logic                 resetn,   // async reset, active low
    input  wire logic                 push,     // store pushData
    input  wire logic [`PC_W-1:0]     pushData, // return address
    input  wire logic                 pop,      // drop top entry
    output logic      [`PC_W-1:0]     top       // current top entry
);
    logic [`PC_W-1:0]        entry [`STACK_DEPTH];  // storage
    logic [`PC_W-1:0]        next_entry [`STACK_DEPTH];
    logic [`STACK_PTR_W-1:0] ptr;                    // points at top
    logic [`STACK_PTR_W-1:0] next_ptr;

    assign top = entry[ptr];

    // pointer update
    always_comb begin
        next_ptr = ptr;
        if (push) begin
            next_ptr = ptr + 3'h1;
        end else if (pop) begin
            next_ptr = ptr - 3'h1;
        end
    end

    // per-entry write on push
    genvar i;
    generate
        for (i = 0; i < `STACK_DEPTH; i++) begin : g_ent
            always_comb begin
                next_entry[i] = entry[i];
                if (push && int'(next_ptr) == i) begin
                    next_entry[i] = pushData;
                end
            end
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    entry[i] <= 13'h0000;
                end else begin
                    entry[i] <= next_entry[i];
                end
            end
        end
    endgenerate

    // pointer register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ptr <= 3'h0;
        end else begin
            ptr <= next_ptr;
        end
    end
endmodule

// ### exec_slice.sv
// Purpose: execute slice for a subset of a 14-bit instruction set
// Assumes: one instruction word per clock, file data read combinationally
// Notes:   timer config, irq control and upper latch live here
// Functional notes
// - jump loads eleven target bits
// - jump upper bits from latch bits 4:3
// - jump takes two cycles, flushing
// - increment adds one, zero flag, one cycle
// - increment-skip on zero flushes, flags untouched
// - destination bit selects accumulator or file
// - or literal into accumulator, zero flag
// - or accumulator with file, zero flag
// - literal load, one cycle, no flags
// - file move to selected destination
// - file move always updates zero flag
// - store accumulator into file, no flags
// - legacy load copies accumulator to timer config
// - timer config is also addressable file
// - return from irq pops stack, two cycles
// - return from irq sets global enable
// - return literal loads accumulator and counter
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "exec_cfg.svh"
module exec_slice (
    input  wire logic                 ref_clk,       // instruction clock
    input  wire logic                 resetn,        // async reset, low
    input  wire logic [13:0]          instrWord,     // fetched word
    input  wire logic [7:0]           fileReadData,  // data at the word's addr field
    output logic      [6:0]           fileAddr,      // registered address
    output logic      [7:0]           fileWriteData, // registered data
    output logic                      fileWrite,     // write pulse
    output logic      [`PC_W-1:0]     programCounter,// fetch address
    output logic      [7:0]           accumulator,   // working register
    output logic                      zeroFlag,      // zero status
    output logic      [7:0]           timerConfig,   // timer config reg
    output logic      [7:0]           irqControl,    // irq control reg
    output logic      [7:0]           upperLatch,    // upper counter latch
    output logic                      flushing       // idle flush cycle
);
    exec_pkg::decode_type dec;          // decoded current word
    exec_pkg::phase_type  phase;        // run or flush
    exec_pkg::phase_type  next_phase;
    logic [`PC_W-1:0]     next_pc;
    logic [7:0]           next_acc;
    logic                 next_zero;
    logic [7:0]           next_timer;
    logic [7:0]           next_irq;
    logic [7:0]           next_latch;
    logic [6:0]           next_faddr;
    logic [7:0]           next_fdata;
    logic                 next_fwrite;
    logic                 stackPop;     // pop request
    logic [`PC_W-1:0]     stackTop;     // current top of stack
    logic [7:0]           operand;      // file operand incl. local regs
    logic [7:0]           result;       // alu result
    logic                 toFile;       // result goes to a file register
    logic                 active;       // instruction is executed

    instr_decode u_dec (
        .word (instrWord),
        .dec  (dec)
    );

    return_stack u_stack (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .push     (1'b0),
        .pushData (13'h0000),
        .pop      (stackPop),
        .top      (stackTop)
    );

    // local registers answer reads of their own addresses
    always_comb begin
        operand = fileReadData;
        if (dec.addr == `ADDR_TIMER_CFG) begin
            operand = timerConfig;
        end else if (dec.addr == `ADDR_IRQ_CTRL) begin
            operand = irqControl;
        end else if (dec.addr == `ADDR_UPPER_LATCH) begin
            operand = upperLatch;
        end
    end

    // execute: next values of all architectural state
    always_comb begin
        active      = (phase == exec_pkg::ST_RUN);
        next_phase  = exec_pkg::ST_RUN;
        next_pc     = programCounter + 13'h0001;
        next_acc    = accumulator;
        next_zero   = zeroFlag;
        next_timer  = timerConfig;
        next_irq    = irqControl;
        next_latch  = upperLatch;
        next_faddr  = fileAddr;
        next_fdata  = fileWriteData;
        next_fwrite = 1'b0;
        stackPop    = 1'b0;
        result      = operand;
        toFile      = 1'b0;
        if (active) begin
            unique case (dec.op)
                exec_pkg::OP_JUMP: begin
                    next_pc = {upperLatch[`LATCH_HI_BIT:`LATCH_LO_BIT],
                               dec.target};
                    next_phase = exec_pkg::ST_FLUSH;
                end
                exec_pkg::OP_INC: begin
                    result    = operand + 8'h01;
                    next_zero = (result == 8'h00);
                    toFile    = dec.dest;
                    if (!dec.dest) begin
                        next_acc = result;
                    end
                end
                exec_pkg::OP_INC_SKIP: begin
                    result = operand + 8'h01;
                    toFile = dec.dest;
                    if (!dec.dest) begin
                        next_acc = result;
                    end
                    if (result == 8'h00) begin
                        next_phase = exec_pkg::ST_FLUSH;
                    end
                end
                exec_pkg::OP_OR_LIT: begin
                    result    = accumulator | dec.lit;
                    next_acc  = result;
                    next_zero = (result == 8'h00);
                end
                exec_pkg::OP_OR_FILE: begin
                    result    = accumulator | operand;
                    next_zero = (result == 8'h00);
                    toFile    = dec.dest;
                    if (!dec.dest) begin
                        next_acc = result;
                    end
                end
                exec_pkg::OP_LOAD_LIT: begin
                    next_acc = dec.lit;
                end
                exec_pkg::OP_MOVE: begin
                    result    = operand;
                    next_zero = (result == 8'h00);
                    toFile    = dec.dest;
                    if (!dec.dest) begin
                        next_acc = result;
                    end
                end
                exec_pkg::OP_STORE: begin
                    result = accumulator;
                    toFile = 1'b1;
                end
                exec_pkg::OP_CFG_LOAD: begin
                    next_timer = accumulator;
                end
                exec_pkg::OP_RET_IRQ: begin
                    stackPop   = 1'b1;
                    next_pc    = stackTop;
                    next_irq[`IRQ_ENABLE_BIT] = 1'b1;
                    next_phase = exec_pkg::ST_FLUSH;
                end
                exec_pkg::OP_RET_LIT: begin
                    stackPop   = 1'b1;
                    next_acc   = dec.lit;
                    next_pc    = stackTop;
                    next_phase = exec_pkg::ST_FLUSH;
                end
                exec_pkg::OP_IDLE: begin
                    next_pc = programCounter + 13'h0001;
                end
                exec_pkg::OP_OTHER: begin
                    next_pc = programCounter + 13'h0001;
                end
            endcase
            // file write-back, local registers captured here
            if (toFile) begin
                if (dec.addr == `ADDR_TIMER_CFG) begin
                    next_timer = result;
                end else if (dec.addr == `ADDR_IRQ_CTRL) begin
                    next_irq = result;
                end else if (dec.addr == `ADDR_UPPER_LATCH) begin
                    next_latch = result;
                end
                next_faddr  = dec.addr;
                next_fdata  = result;
                next_fwrite = 1'b1;
            end
        end
    end

    // register all state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase          <= exec_pkg::ST_RUN;
            programCounter <= `PC_RESET;
            accumulator    <= 8'h00;
            zeroFlag       <= 1'b0;
            timerConfig    <= `TIMER_CFG_RESET;
            irqControl     <= 8'h00;
            upperLatch     <= 8'h00;
            fileAddr       <= 7'h00;
            fileWriteData  <= 8'h00;
            fileWrite      <= 1'b0;
            flushing       <= 1'b0;
        end else begin
            phase          <= next_phase;
            programCounter <= next_pc;
            accumulator    <= next_acc;
            zeroFlag       <= next_zero;
            timerConfig    <= next_timer;
            irqControl     <= next_irq;
            upperLatch     <= next_latch;
            fileAddr       <= next_faddr;
            fileWriteData  <= next_fdata;
            fileWrite      <= next_fwrite;
            flushing       <= (next_phase == exec_pkg::ST_FLUSH);
        end
    end

    // checks
    logic run;
    assign run = (phase == exec_pkg::ST_RUN);

    jump_target_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_JUMP |=> programCounter ==
        {$past(upperLatch[4:3]), $past(dec.target)})
        else $error("jump target wrong");
    jump_flush_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_JUMP |=> flushing ##1 !flushing)
        else $error("jump flush missing");
    inc_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_INC |=>
        zeroFlag == ($past(operand) == 8'hFF))
        else $error("increment zero flag wrong");
    skip_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_INC_SKIP |=>
        $stable(zeroFlag) && flushing == ($past(operand) == 8'hFF))
        else $error("skip behaviour wrong");
    or_literal_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_OR_LIT |=>
        accumulator == ($past(accumulator) | $past(dec.lit)))
        else $error("or literal wrong");
    load_literal_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_LOAD_LIT |=>
        accumulator == $past(dec.lit) && $stable(zeroFlag))
        else $error("load literal wrong");
    move_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_MOVE |=>
        zeroFlag == ($past(operand) == 8'h00))
        else $error("move zero flag wrong");
    store_file_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_STORE |=>
        fileWrite && fileWriteData == $past(accumulator))
        else $error("store wrong");
    cfg_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_CFG_LOAD |=>
        timerConfig == $past(accumulator) && $stable(zeroFlag))
        else $error("config load wrong");
    irq_enable_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_RET_IRQ |=>
        irqControl[7] && programCounter == $past(stackTop))
        else $error("return from irq wrong");
    or_file_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_OR_FILE |=>
        zeroFlag == (($past(accumulator) | $past(operand)) == 8'h00))
        else $error("or file zero flag wrong");
    move_dest_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_MOVE && !dec.dest |=>
        accumulator == $past(operand) && !fileWrite)
        else $error("move to accumulator wrong");
    file_dest_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        run && dec.dest && (dec.op == exec_pkg::OP_INC ||
        dec.op == exec_pkg::OP_OR_FILE || dec.op == exec_pkg::OP_MOVE) |=>
        fileWrite && fileAddr == $past(dec.addr))
        else $error("file destination wrong");
    ret_lit_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_RET_LIT |=> flushing &&
        accumulator == $past(dec.lit) && programCounter == $past(stackTop))
        else $error("return with literal wrong");
    idle_state_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_IDLE |=> !fileWrite &&
        $stable(accumulator) && $stable(zeroFlag) && $stable(timerConfig))
        else $error("idle changed state");

    jump_seen_c: cover property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_JUMP);
    skip_taken_c: cover property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_INC_SKIP ##1 flushing);
    ret_lit_c: cover property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_RET_LIT);
    ret_irq_c: cover property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_RET_IRQ);
    store_seen_c: cover property (@(posedge ref_clk) disable iff (!resetn)
        run && dec.op == exec_pkg::OP_STORE);
endmodule

// ### exec_slice_tb_top.sv
// Purpose: self-checking bench for the instruction execute slice
// Assumes: the bench acts as program memory and as the file register array
// Notes:   each word is followed by an idle word; branches get a follower
`timescale 1ns/1ps
`include "exec_cfg.svh"
module exec_slice_tb_top;
    localparam logic [13:0] IDLE_WORD = 14'h0000; // plain idle word
    localparam logic [13:0] FOLLOWER  = 14'h3077; // load that must be dropped
    logic                 ref_clk;          // instruction clock
    logic                 resetn;           // async reset, active low
    logic [13:0]          instrWord;        // word presented to the slice
    logic [7:0]           fileReadData;     // file array read port
    logic [6:0]           fileAddr;         // slice write address
    logic [7:0]           fileWriteData;    // slice write data
    logic                 fileWrite;        // slice write pulse
    logic [`PC_W-1:0]     programCounter;   // fetch address
    logic [7:0]           accumulator;      // working register
    logic                 zeroFlag;         // zero status
    logic [7:0]           timerConfig;      // timer config register
    logic [7:0]           irqControl;       // irq control register
    logic [7:0]           upperLatch;       // upper counter latch
    logic                 flushing;         // flush cycle marker
    logic [13:0]          nextWord;         // one-shot word for next edge
    logic [7:0]           fmem [0:127];     // file register array model
    logic [7:0]           eAcc, eTc, eIrq, eLatch, eData; // expected values
    logic                 eZ, eWr, eFlush;  // expected flags, eWr x = no write check
    logic [6:0]           eAddr;            // expected write address
    logic [`PC_W-1:0]     ePc;              // expected fetch address
    logic [7:0]           latchVals [2] = '{8'h0E, 8'h10}; // latch cases
    logic [10:0]          targets [2] = '{11'h123, 11'h7FF}; // jump targets
    logic [13:0]          idleWords [4] = '{14'h0000, 14'h0020,
                                            14'h0040, 14'h0060};
    int                   badCount;         // mismatches seen
    int                   checked;          // comparisons made

    exec_slice DUT (
        .ref_clk        (ref_clk),
        .resetn         (resetn),
        .instrWord      (instrWord),
        .fileReadData   (fileReadData),
        .fileAddr       (fileAddr),
        .fileWriteData  (fileWriteData),
        .fileWrite      (fileWrite),
        .programCounter (programCounter),
        .accumulator    (accumulator),
        .zeroFlag       (zeroFlag),
        .timerConfig    (timerConfig),
        .irqControl     (irqControl),
        .upperLatch     (upperLatch),
        .flushing       (flushing)
    );

    // free running clock, 20 ns period
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    // word driver: takes the one-shot word at each edge, then falls to idle
    always @(posedge ref_clk) begin
        instrWord <= nextWord;
        nextWord = IDLE_WORD;
    end

    // file array: combinational read, write on the slice's pulse
    assign fileReadData = fmem[instrWord[6:0]];
    always @(posedge ref_clk) begin
        if (fileWrite === 1'b1) begin
            fmem[fileAddr] <= fileWriteData;
        end
    end

    // compare tasks, one per result width
    task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
        checked++;
        if (got !== want) begin
            badCount++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic cmp1(input logic got, input logic want);
        checked++;
        if (got !== want) begin
            badCount++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic cmp13(input logic [12:0] got, input logic [12:0] want);
        checked++;
        if (got !== want) begin
            badCount++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // compare every output against the expected state, write address and data only when a write is expected
    task automatic chk;
        cmp8(accumulator, eAcc);
        cmp1(zeroFlag, eZ);
        cmp13(programCounter, ePc);
        cmp1(flushing, eFlush);
        if (eWr !== 1'bx) begin
            cmp1(fileWrite, eWr);
        end
        if (eWr === 1'b1) begin
            cmp8({1'b0, fileAddr}, {1'b0, eAddr});
            cmp8(fileWriteData, eData);
        end
        cmp8(timerConfig, eTc);
        cmp8(irqControl, eIrq);
        cmp8(upperLatch, eLatch);
    endtask

    // one clock; outputs are read once the edge has settled
    task automatic cyc;
        @(posedge ref_clk);
        #1;
        ePc = ePc + 13'h0001;
    endtask

    // one word, preceded by the trailing idle of the previous one
    task automatic step(input logic [13:0] w);
        nextWord = w;
        eWr = 1'b0;
        eFlush = 1'b0;
        cyc();
        cyc();
    endtask

    // branch word directly followed by a word that must be dropped
    task automatic branch(input logic [13:0] w);
        nextWord = w;
        eWr = 1'b0;
        eFlush = 1'b1;
        cyc();
        nextWord = FOLLOWER;
        cyc();
    endtask

    // the flush cycle: follower ignored, counter just increments
    task automatic ignored;
        eWr = 1'b0;
        eFlush = 1'b0;
        cyc();
        chk();
    endtask

    // expected file write
    task automatic expw(input logic [6:0] a, input logic [7:0] d);
        eWr = 1'b1;
        eAddr = a;
        eData = d;
    endtask

    // verdict and end of run
    task automatic finalReport;
        $display("mismatches %0d, comparisons %0d", badCount, checked);
        if (badCount == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        #200000;
        badCount++;
        finalReport();
    end

    // main sequence
    initial begin
        badCount = 0;
        checked = 0;
        resetn = 1'b0;
        instrWord = IDLE_WORD;
        nextWord = IDLE_WORD;
        for (int k = 0; k < 128; k++) begin
            fmem[k] = 8'h00;
        end
        fmem[1] = 8'hFF;
        fmem[7'h21] = 8'h3C;
        fmem[7'h23] = 8'hFF;
        fmem[7'h24] = 8'h41;
        {eAcc, eZ, eIrq, eLatch, eFlush, eWr} = '0;
        eTc = 8'hFF;
        ePc = 13'h0000;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        chk();
        step(14'h3800); eZ = 1'b1; chk();
        step(14'h3355); eAcc = 8'h55; chk();
        step(14'h38A0); eAcc = 8'hF5; eZ = 1'b0; chk();
        step(14'h00A0); expw(7'h20, 8'hF5); chk();
        step(14'h0421); eAcc = 8'hFD; chk();
        step(14'h3000); eAcc = 8'h00; chk();
        step(14'h04A2); eZ = 1'b1; expw(7'h22, 8'h00); chk();
        step(14'h0821); eAcc = 8'h3C; eZ = 1'b0; chk();
        step(14'h08A2); eZ = 1'b1; expw(7'h22, 8'h00); chk();
        step(14'h0AA1); eZ = 1'b0; expw(7'h21, 8'h3D); chk();
        step(14'h0A23); eAcc = 8'h00; eZ = 1'b1; chk();
        step(14'h0F24); eAcc = 8'h42; chk();
        step(14'h3801); eAcc = 8'h43; eZ = 1'b0; chk();
        branch(14'h0FA3); expw(7'h23, 8'h00); chk();
        ignored();
        // legacy config load, then the same register as a plain file
        step(14'h305C); eAcc = 8'h5C;
        step(14'h0062); eTc = 8'h5C; chk();
        // read of the local address must see 5C, not the array's FF
        step(14'h0801); chk();
        step(14'h30A3); eAcc = 8'hA3;
        step(14'h0081); eTc = 8'hA3; expw(7'h01, 8'hA3); chk();
        // jumps with different latch contents, a mid target and the top target
        for (int i = 0; i < 2; i++) begin
            step({6'h30, latchVals[i]}); eAcc = latchVals[i];
            step(14'h008A); eLatch = latchVals[i];
            expw(7'h0A, latchVals[i]); chk();
            branch({3'b101, targets[i]});
            ePc = {latchVals[i][4:3], targets[i]}; chk();
            ignored();
        end
        // return from interrupt sets the enable beside the low bits
        step(14'h3005); eAcc = 8'h05;
        step(14'h008B); eIrq = 8'h05; expw(7'h0B, 8'h05); chk();
        branch(14'h0009); eIrq = 8'h85;
        ePc = 13'h0000; chk();
        ignored();
        branch(14'h37C3); eAcc = 8'hC3; ePc = 13'h0000; chk();
        ignored();
        // every idle encoding leaves all state but the counter alone
        for (int j = 0; j < 4; j++) begin
            step(idleWords[j]); chk();
        end
        // a word outside the subset only moves the counter
        step(14'h0100); chk();
        finalReport();
    end
endmodule
